// >>> hw/route_cfg_pkg.sv
/*
 * Shared constants and carriers for the external bus route selection
 * register and its pad multiplexers.
 * Assumes one CPU clock and an I/O port space with 16-bit addresses and data.
 */
package route_cfg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ROUTE_SEL_ADDR  = 16'h1C00;
    localparam logic [15:0] ROUTE_SEL_RESET = 16'h0000;
    localparam logic [15:0] ROUTE_SEL_WMASK = 16'h7F3F;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int PP_MODE_LSB = 12;
    localparam int PP_MODE_W   = 3;
    localparam int SP1_MODE_LSB = 10;
    localparam int SP0_MODE_LSB = 8;
    localparam int SP_MODE_W   = 2;
    localparam int AGPIO_LSB   = 0;

    // ------------------------------------------------------------------
    // default sizes
    // ------------------------------------------------------------------
    localparam int PP_PINS     = 21;
    localparam int PP_SOURCES  = 6;
    localparam int SP_PINS     = 6;
    localparam int SP_PORTS    = 2;
    localparam int ADDR_GPIO_W = 6;

    // ------------------------------------------------------------------
    // parallel port sources, indexed by mode; modes above gpio pick gpio
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PP_LCD, PP_AUD2, PP_AUD3, PP_UART, PP_SPI, PP_GPIO
    } pp_src_e;

    // serial port group modes
    localparam logic [1:0] SP_MODE_CARD  = 2'h0;
    localparam logic [1:0] SP_MODE_AUDIO = 2'h1;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } io_req_s;

    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
    } io_rsp_s;

endpackage

// >>> hw/reset_strap.sv
/*
 * Supply-good, internal reset and clock-source strap capture.
 * Assumes arst_n is the external reset pin and regulator_above_min comes from
 * the analog power-on monitor, both already synchronous to ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_strap
(
    // clock and external reset pin
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // straps and monitor
    input  wire logic core_regulator_enable_pin,
    input  wire logic regulator_above_min,
    input  wire logic clock_source_select_pin,
    // results
    output logic      core_supply_ok,
    output logic      internal_reset_n,
    output logic      clk_gen_from_ext
);

    typedef struct packed {
        logic ok;
        logic rst_meta;
        logic rst;
        logic ext;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        // regulator off: monitor bypassed, else monitor
        nxt_state.ok       = core_regulator_enable_pin | regulator_above_min;
        // pin low clears both stages at once, supply loss within two edges
        nxt_state.rst_meta = state_ff.ok;
        nxt_state.rst      = state_ff.rst_meta & state_ff.ok;
        // strap sampled only while held in reset, frozen after
        if (!state_ff.rst)
        begin
            nxt_state.ext = clock_source_select_pin;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign core_supply_ok   = state_ff.ok;
    assign internal_reset_n = state_ff.rst;
    assign clk_gen_from_ext = state_ff.ext;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_supply_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!core_regulator_enable_pin && !regulator_above_min) |=> !core_supply_ok)
        else $error("supply ok raised without monitor");

    a_ldo_bypass: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (arst_n && core_regulator_enable_pin) |=> core_supply_ok)
        else $error("bypass did not raise supply ok");

    a_reset_and: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !core_supply_ok |=> !internal_reset_n)
        else $error("internal reset not held on supply loss");

    a_clock_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (internal_reset_n && $past(internal_reset_n)) |-> $stable(clk_gen_from_ext))
        else $error("clock source changed in operation");

endmodule

`default_nettype wire

// >>> hw/bus_route_top.sv
/*
 * Reset configuration and external bus route selection register, with the
 * pad multiplexers for the parallel port, two serial ports and the upper
 * memory address pins.
 * Assumes peripherals present per-pin out/oe vectors on ref_clk and that the
 * CPU issues single-cycle I/O port requests.
 */
`timescale 1ns/1ns
`default_nettype none


module bus_route_top
#(
    parameter int PP_PINS     = route_cfg_pkg::PP_PINS,
    parameter int PP_SOURCES  = route_cfg_pkg::PP_SOURCES,
    parameter int SP_PINS     = route_cfg_pkg::SP_PINS,
    parameter int SP_PORTS    = route_cfg_pkg::SP_PORTS,
    parameter int ADDR_GPIO_W = route_cfg_pkg::ADDR_GPIO_W
)
(
    // clock, reset pin, straps
    input  wire logic                                   ref_clk,
    input  wire logic                                   arst_n,
    input  wire logic                                   core_regulator_enable_pin,
    input  wire logic                                   regulator_above_min,
    input  wire logic                                   clock_source_select_pin,
    // reset and clock results
    output logic                                        core_supply_ok,
    output logic                                        internal_reset_n,
    output logic                                        clk_gen_from_ext,
    // I/O port access
    input  wire route_cfg_pkg::io_req_s                 io_req,
    output route_cfg_pkg::io_rsp_s                      io_rsp,
    // parallel port: sources and pads
    input  wire logic [PP_SOURCES-1:0][PP_PINS-1:0]     pp_src_out,
    input  wire logic [PP_SOURCES-1:0][PP_PINS-1:0]     pp_src_oe,
    output logic      [PP_SOURCES-1:0][PP_PINS-1:0]     pp_src_in,
    input  wire logic [PP_PINS-1:0]                     pp_pin_in,
    output logic      [PP_PINS-1:0]                     pp_pin_out,
    output logic      [PP_PINS-1:0]                     pp_pin_oe,
    // serial port groups: card and audio sources and pads
    input  wire logic [SP_PORTS-1:0][SP_PINS-1:0]       sp_card_out,
    input  wire logic [SP_PORTS-1:0][SP_PINS-1:0]       sp_card_oe,
    output logic      [SP_PORTS-1:0][SP_PINS-1:0]       sp_card_in,
    input  wire logic [SP_PORTS-1:0][SP_PINS-1:0]       sp_audio_out,
    input  wire logic [SP_PORTS-1:0][SP_PINS-1:0]       sp_audio_oe,
    output logic      [SP_PORTS-1:0][SP_PINS-1:0]       sp_audio_in,
    input  wire logic [SP_PORTS-1:0][SP_PINS-1:0]       sp_pin_in,
    output logic      [SP_PORTS-1:0][SP_PINS-1:0]       sp_pin_out,
    output logic      [SP_PORTS-1:0][SP_PINS-1:0]       sp_pin_oe,
    // upper memory address pins
    input  wire logic [ADDR_GPIO_W-1:0]                 mem_addr_hi,
    input  wire logic [ADDR_GPIO_W-1:0]                 addr_gpio_out,
    input  wire logic [ADDR_GPIO_W-1:0]                 addr_gpio_oe,
    output logic      [ADDR_GPIO_W-1:0]                 addr_gpio_in,
    input  wire logic [ADDR_GPIO_W-1:0]                 addr_pin_in,
    output logic      [ADDR_GPIO_W-1:0]                 addr_pin_out,
    output logic      [ADDR_GPIO_W-1:0]                 addr_pin_oe
);

    // ------------------------------------------------------------------
    // reset and strap logic
    // ------------------------------------------------------------------
    reset_strap u_reset_strap
    (
        .ref_clk                   (ref_clk),
        .arst_n                    (arst_n),
        .core_regulator_enable_pin (core_regulator_enable_pin),
        .regulator_above_min       (regulator_above_min),
        .clock_source_select_pin   (clock_source_select_pin),
        .core_supply_ok            (core_supply_ok),
        .internal_reset_n          (internal_reset_n),
        .clk_gen_from_ext          (clk_gen_from_ext)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                         route;
        route_cfg_pkg::io_rsp_s              rsp;
        logic [PP_SOURCES-1:0][PP_PINS-1:0]  pp_in;
        logic [PP_PINS-1:0]                  pp_out;
        logic [PP_PINS-1:0]                  pp_oe;
        logic [SP_PORTS-1:0][SP_PINS-1:0]    card_in;
        logic [SP_PORTS-1:0][SP_PINS-1:0]    audio_in;
        logic [SP_PORTS-1:0][SP_PINS-1:0]    sp_out;
        logic [SP_PORTS-1:0][SP_PINS-1:0]    sp_oe;
        logic [ADDR_GPIO_W-1:0]              ag_in;
        logic [ADDR_GPIO_W-1:0]              a_out;
        logic [ADDR_GPIO_W-1:0]              a_oe;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    // ------------------------------------------------------------------
    // decoded fields of the register in force
    // ------------------------------------------------------------------
    logic [route_cfg_pkg::PP_MODE_W-1:0]  pp_mode;
    logic [2:0]                           pp_src;
    logic [SP_PORTS-1:0][1:0]             sp_mode;
    logic [ADDR_GPIO_W-1:0]               agpio_sel;
    logic                                 hit;

    assign pp_mode   = state_ff.route[route_cfg_pkg::PP_MODE_LSB +: route_cfg_pkg::PP_MODE_W];
    // reserved modes fall back to gpio so no pad is left undriven by mistake
    assign pp_src    = (pp_mode > 3'(route_cfg_pkg::PP_GPIO)) ? 3'(route_cfg_pkg::PP_GPIO) : pp_mode;
    assign sp_mode[0] = state_ff.route[route_cfg_pkg::SP0_MODE_LSB +: route_cfg_pkg::SP_MODE_W];
    assign sp_mode[1] = state_ff.route[route_cfg_pkg::SP1_MODE_LSB +: route_cfg_pkg::SP_MODE_W];
    assign agpio_sel = state_ff.route[route_cfg_pkg::AGPIO_LSB +: ADDR_GPIO_W];
    assign hit       = (io_req.addr == route_cfg_pkg::ROUTE_SEL_ADDR);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;

        // port write; bit 15 and other unused bits stay zero
        if (io_req.wr && hit)
        begin
            nxt_state.route = io_req.wdata & route_cfg_pkg::ROUTE_SEL_WMASK;
        end

        // read back what is in force, zero on unmapped ports
        nxt_state.rsp.rvalid = io_req.rd;
        nxt_state.rsp.rdata  = (io_req.rd && hit) ? state_ff.route : 16'h0000;

        // pads follow the stored register one edge later
        for (int s = 0; s < PP_SOURCES; s++)
        begin
            nxt_state.pp_in[s] = (3'(s) == pp_src) ? pp_pin_in : '0;
        end
        nxt_state.pp_out = pp_src_out[pp_src];
        nxt_state.pp_oe  = pp_src_oe[pp_src];

        for (int g = 0; g < SP_PORTS; g++)
        begin
            case (sp_mode[g])
                route_cfg_pkg::SP_MODE_CARD:
                begin
                    nxt_state.sp_out[g]   = sp_card_out[g];
                    nxt_state.sp_oe[g]    = sp_card_oe[g];
                    nxt_state.card_in[g]  = sp_pin_in[g];
                    nxt_state.audio_in[g] = '0;
                end
                route_cfg_pkg::SP_MODE_AUDIO:
                begin
                    nxt_state.sp_out[g]   = sp_audio_out[g];
                    nxt_state.sp_oe[g]    = sp_audio_oe[g];
                    nxt_state.card_in[g]  = '0;
                    nxt_state.audio_in[g] = sp_pin_in[g];
                end
                default:
                begin
                    // unused codes park the group as inputs
                    nxt_state.sp_out[g]   = '0;
                    nxt_state.sp_oe[g]    = '0;
                    nxt_state.card_in[g]  = '0;
                    nxt_state.audio_in[g] = '0;
                end
            endcase
        end

        for (int b = 0; b < ADDR_GPIO_W; b++)
        begin
            nxt_state.a_out[b] = agpio_sel[b] ? addr_gpio_out[b] : mem_addr_hi[b];
            nxt_state.a_oe[b]  = agpio_sel[b] ? addr_gpio_oe[b]  : 1'b1;
            nxt_state.ag_in[b] = agpio_sel[b] & addr_pin_in[b];
        end
    end

    // reset leaves the memory address pins driven, matching the register default
    always_ff @(posedge ref_clk or negedge internal_reset_n)
    begin
        if (!internal_reset_n)
        begin
            state_ff       <= '0;
            state_ff.route <= route_cfg_pkg::ROUTE_SEL_RESET;
            state_ff.a_oe  <= '1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign io_rsp       = state_ff.rsp;
    assign pp_src_in    = state_ff.pp_in;
    assign pp_pin_out   = state_ff.pp_out;
    assign pp_pin_oe    = state_ff.pp_oe;
    assign sp_card_in   = state_ff.card_in;
    assign sp_audio_in  = state_ff.audio_in;
    assign sp_pin_out   = state_ff.sp_out;
    assign sp_pin_oe    = state_ff.sp_oe;
    assign addr_gpio_in = state_ff.ag_in;
    assign addr_pin_out = state_ff.a_out;
    assign addr_pin_oe  = state_ff.a_oe;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_route_write;
        io_req.wr && (io_req.addr == route_cfg_pkg::ROUTE_SEL_ADDR);
    endsequence

    // sampled reset in antecedents: the release edge still shows reset values on the pads

    a_reg_decode: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        (io_req.wr && io_req.addr != route_cfg_pkg::ROUTE_SEL_ADDR) |=> $stable(state_ff.route))
        else $error("route register written at wrong port");

    a_write_store: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        s_route_write |=> state_ff.route == ($past(io_req.wdata) & route_cfg_pkg::ROUTE_SEL_WMASK))
        else $error("route register did not take the write");

    a_route_next: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        s_route_write ##1 (!io_req.wr && $stable(pp_src_out)) |=>
            pp_pin_out == pp_src_out[pp_src])
        else $error("parallel routing late after write");

    a_pp_route: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        (internal_reset_n && !io_req.wr) |=> pp_pin_oe == $past(pp_src_oe[pp_src]))
        else $error("parallel pad enable from wrong source");

    a_sp_audio: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        (internal_reset_n && sp_mode[0] == route_cfg_pkg::SP_MODE_AUDIO) |=>
            (sp_pin_out[0] == $past(sp_audio_out[0])) && (sp_card_in[0] == '0))
        else $error("serial group 0 not routed to audio");

    a_sp_card: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        (internal_reset_n && sp_mode[1] == route_cfg_pkg::SP_MODE_CARD) |=>
            (sp_card_in[1] == $past(sp_pin_in[1])) && (sp_audio_in[1] == '0))
        else $error("serial group 1 not routed to card");

    a_addr_gpio: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        internal_reset_n |=> addr_pin_out == (($past(agpio_sel) & $past(addr_gpio_out)) |
                                  (~$past(agpio_sel) & $past(mem_addr_hi))))
        else $error("address pin function wrong");

    a_read_back: assert property (@(posedge ref_clk) disable iff (!internal_reset_n)
        (io_req.rd && io_req.addr == route_cfg_pkg::ROUTE_SEL_ADDR) |=>
            io_rsp.rvalid && (io_rsp.rdata == $past(state_ff.route)))
        else $error("read did not return routing in force");

endmodule

`default_nettype wire

// >>> sim/route_partner.sv
/*
 * Far-side model for bus_route_top: peripheral sources and board pads.
 * Assumes the bench reads pads only after they settle; every source drives
 * its own fixed word so that a wrong select or a missing gate shows up.
 */
`timescale 1ns/1ns
`default_nettype none

module route_partner
#(
    parameter int PP_PINS     = route_cfg_pkg::PP_PINS,
    parameter int PP_SOURCES  = route_cfg_pkg::PP_SOURCES,
    parameter int SP_PINS     = route_cfg_pkg::SP_PINS,
    parameter int SP_PORTS    = route_cfg_pkg::SP_PORTS,
    parameter int ADDR_GPIO_W = route_cfg_pkg::ADDR_GPIO_W
)
(
    // parallel port
    output logic [PP_SOURCES-1:0][PP_PINS-1:0] pp_src_out,
    output logic [PP_SOURCES-1:0][PP_PINS-1:0] pp_src_oe,
    output logic [PP_PINS-1:0]                 pp_pin_in,
    // serial groups
    output logic [SP_PORTS-1:0][SP_PINS-1:0]   sp_card_out,
    output logic [SP_PORTS-1:0][SP_PINS-1:0]   sp_card_oe,
    output logic [SP_PORTS-1:0][SP_PINS-1:0]   sp_audio_out,
    output logic [SP_PORTS-1:0][SP_PINS-1:0]   sp_audio_oe,
    output logic [SP_PORTS-1:0][SP_PINS-1:0]   sp_pin_in,
    // address pins
    output logic [ADDR_GPIO_W-1:0]             addr_gpio_out,
    output logic [ADDR_GPIO_W-1:0]             addr_gpio_oe,
    output logic [ADDR_GPIO_W-1:0]             addr_pin_in
);
    // sources never move, as if gated across route writes
    // and as if reset after them, no stale peripheral state
    // enables differ from data so swapped out/oe paths are caught
    always_comb
    begin
        for (int s = 0; s < PP_SOURCES; s++)
        begin
            pp_src_out[s] = PP_PINS'(32'h00123457 * (s + 1));
            pp_src_oe[s]  = PP_PINS'(32'h000A6C93 * (s + 3));
        end
        pp_pin_in = PP_PINS'(32'h0015AA5C);
        for (int p = 0; p < SP_PORTS; p++)
        begin
            sp_card_out[p]  = SP_PINS'(32'h00000015 + p);
            sp_card_oe[p]   = SP_PINS'(32'h0000002E - p);
            sp_audio_out[p] = SP_PINS'(32'h00000033 ^ p);
            sp_audio_oe[p]  = SP_PINS'(32'h0000000C + p);
            sp_pin_in[p]    = SP_PINS'(32'h00000039 - p);
        end
        addr_gpio_out = ADDR_GPIO_W'(32'h00000036);
        addr_gpio_oe  = ADDR_GPIO_W'(32'h0000001B);
        addr_pin_in   = ADDR_GPIO_W'(32'h00000027);
    end
endmodule

`default_nettype wire

// >>> sim/reset_config_and_bus_select_tb.sv
/*
 * Self-checking bench for bus_route_top with route_partner on the pad side.
 * Assumes a 100 MHz ref_clk and single-cycle I/O port requests.
 */
`timescale 1ns/1ns
`default_nettype none

module reset_config_and_bus_select_tb;
    localparam logic [15:0] RA = route_cfg_pkg::ROUTE_SEL_ADDR;
    typedef struct packed { logic [15:0] wdata; logic [15:0] rdata; logic [2:0] src; } row_s;

    logic ref_clk = 1'b0, arst_n = 1'b0, core_regulator_enable_pin = 1'b1;
    logic regulator_above_min = 1'b0, clock_source_select_pin = 1'b1;
    logic core_supply_ok, internal_reset_n, clk_gen_from_ext;
    route_cfg_pkg::io_req_s io_req = '0;
    route_cfg_pkg::io_rsp_s io_rsp;
    logic [5:0][20:0] pp_src_out, pp_src_oe, pp_src_in;
    logic [20:0]      pp_pin_in, pp_pin_out, pp_pin_oe;
    logic [1:0][5:0]  sp_card_out, sp_card_oe, sp_card_in, sp_audio_out, sp_audio_oe, sp_audio_in;
    logic [1:0][5:0]  sp_pin_in, sp_pin_out, sp_pin_oe;
    logic [5:0]       mem_addr_hi = 6'h2D;
    logic [5:0]       addr_gpio_out, addr_gpio_oe, addr_gpio_in, addr_pin_in, addr_pin_out, addr_pin_oe;
    int               num_errors = 0, checks_done = 0, cycles = 0;
    logic [2:0]       prev_src;
    row_s             rows [8] = '{'{16'hFFFF, 16'h7F3F, 3'h5}, '{16'h0000, 16'h0000, 3'h0},
                                   '{16'h1501, 16'h1501, 3'h1}, '{16'h2A2A, 16'h2A2A, 3'h2},
                                   '{16'h3415, 16'h3415, 3'h3}, '{16'h40C3, 16'h4003, 3'h4},
                                   '{16'h5F3F, 16'h5F3F, 3'h5}, '{16'h6000, 16'h6000, 3'h5}};

    bus_route_top dut
    (
        .ref_clk, .arst_n, .core_regulator_enable_pin, .regulator_above_min, .clock_source_select_pin,
        .core_supply_ok, .internal_reset_n, .clk_gen_from_ext, .io_req, .io_rsp,
        .pp_src_out, .pp_src_oe, .pp_src_in, .pp_pin_in, .pp_pin_out, .pp_pin_oe,
        .sp_card_out, .sp_card_oe, .sp_card_in, .sp_audio_out, .sp_audio_oe, .sp_audio_in,
        .sp_pin_in, .sp_pin_out, .sp_pin_oe, .mem_addr_hi, .addr_gpio_out, .addr_gpio_oe,
        .addr_gpio_in, .addr_pin_in, .addr_pin_out, .addr_pin_oe
    );

    route_partner far_side
    (
        .pp_src_out, .pp_src_oe, .pp_pin_in, .sp_card_out, .sp_card_oe, .sp_audio_out,
        .sp_audio_oe, .sp_pin_in, .addr_gpio_out, .addr_gpio_oe, .addr_pin_in
    );

    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge ref_clk);
        io_req <= '0;
    endtask

    task automatic io_rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
        @(posedge ref_clk);
        io_req <= '0;
        #1;
        chk("rvalid", io_rsp.rvalid, 1'b1);
        chk("rdata", io_rsp.rdata, exp);
    endtask

    task automatic chk_pads(input logic [15:0] v, input logic [2:0] src);
        logic [1:0] m;
        logic [5:0] g;
        logic [5:0] e_oe;
        logic [5:0] e_out;
        g = v[5:0];
        chk("pp_out", pp_pin_out, pp_src_out[src]);
        chk("pp_oe", pp_pin_oe, pp_src_oe[src]);
        for (int s = 0; s < 6; s++)
            chk("pp_src_in", pp_src_in[s], (s == src) ? pp_pin_in : 21'h000000);
        for (int p = 0; p < 2; p++)
        begin
            m = v[8 + 2 * p +: 2];
            e_oe  = (m == 2'h0) ? sp_card_oe[p] : (m == 2'h1) ? sp_audio_oe[p] : 6'h00;
            e_out = (m == 2'h0) ? sp_card_out[p] : (m == 2'h1) ? sp_audio_out[p] : 6'h00;
            chk("sp_oe", sp_pin_oe[p], e_oe);
            chk("sp_out", sp_pin_out[p], e_out);
            chk("sp_card_in", sp_card_in[p], (m == 2'h0) ? sp_pin_in[p] : 6'h00);
            chk("sp_audio_in", sp_audio_in[p], (m == 2'h1) ? sp_pin_in[p] : 6'h00);
        end
        chk("a_out", addr_pin_out, 6'((g & addr_gpio_out) | (~g & mem_addr_hi)));
        chk("a_oe", addr_pin_oe, 6'((g & addr_gpio_oe) | ~g));
        chk("a_in", addr_gpio_in, 6'(g & addr_pin_in));
    endtask

    task automatic do_reset(input logic regp, input logic csel);
        logic up;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        core_regulator_enable_pin <= regp;
        clock_source_select_pin <= csel;
        repeat (3) @(posedge ref_clk);
        chk("ok_in_reset", core_supply_ok, 1'b0);
        chk("irn_in_reset", internal_reset_n, 1'b0);
        arst_n <= 1'b1;
        up = regp | regulator_above_min;
        @(posedge ref_clk);
        #1;
        chk("supply_ok", core_supply_ok, up);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irn", internal_reset_n, up);
        if (up)
            chk("clk_src", clk_gen_from_ext, csel);
    endtask

    task automatic wait_irn();
        repeat (4)
        begin
            @(posedge ref_clk);
            #1;
            if (internal_reset_n === 1'b1)
                break;
        end
        chk("irn_up", internal_reset_n, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        do_reset(1'b1, 1'b1);
        io_rd(RA, route_cfg_pkg::ROUTE_SEL_RESET);
        prev_src = 3'h0;
        foreach (rows[i])
        begin
            io_wr(RA, rows[i].wdata);
            #1;
            chk("pp_out_old", pp_pin_out, pp_src_out[prev_src]);
            @(posedge ref_clk);
            #1;
            chk_pads(rows[i].rdata, rows[i].src);
            io_rd(RA, rows[i].rdata);
            prev_src = rows[i].src;
        end
        // unmapped port: write ignored, read gives zero
        io_wr(16'h1C02, 16'h0000);
        io_rd(16'h1C02, 16'h0000);
        io_rd(RA, 16'h6000);
        // strap change followed by a device reset
        do_reset(1'b1, 1'b0);
        // regulator on: reset waits for the monitor
        do_reset(1'b0, 1'b0);
        @(posedge ref_clk);
        regulator_above_min <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("ok_after_monitor", core_supply_ok, 1'b1);
        wait_irn();
        io_wr(RA, 16'h1234); // one configuration write after boot
        io_rd(RA, 16'h1234);
        // supply drop mid-run must pull internal reset and clear routing
        @(posedge ref_clk);
        regulator_above_min <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("ok_drop", core_supply_ok, 1'b0);
        chk("irn_lag", internal_reset_n, 1'b1);
        @(posedge ref_clk);
        #1;
        chk("irn_drop", internal_reset_n, 1'b0);
        @(posedge ref_clk);
        regulator_above_min <= 1'b1;
        wait_irn();
        io_rd(RA, 16'h0000);
        tally_and_finish();
    end

    // the sequence needs well under 500 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
endmodule

`default_nettype wire
